/* File: src/cfe_map.vh */
// Purpose: shared constants of the fetch/execute sequencer
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef CFE_MAP_VH
`define CFE_MAP_VH

// quadrature phases, one-hot
`define CFE_PH_ONE       4'h1
`define CFE_PH_TWO       4'h2
`define CFE_PH_THREE     4'h4
`define CFE_PH_FOUR      4'h8
`define CFE_PH_COUNT     4

// program side
`define CFE_PC_W         21
`define CFE_PC_RESET     21'h000000
`define CFE_PC_STEP      21'h000002
`define CFE_WORD_W       16

// data side
`define CFE_DA_W         12
`define CFE_BANK_W       4
`define CFE_DA_BYTES     4096
`define CFE_BANKS        16
`define CFE_USER_BYTES   3808
`define CFE_ACC_SPLIT    8'h60
`define CFE_ACC_LO_BANK  4'h0
`define CFE_ACC_HI_BANK  4'hF

// opcode fields
`define CFE_TAIL_TAG     4'hF
`define CFE_OP_GOTO      8'hEF
`define CFE_OP_CALL      7'h76
`define CFE_OP_LFSR      8'hEE
`define CFE_OP_REGISTER_TO_REGISTER_MOVE     4'hC
`define CFE_OP_BRA       5'h1A
`define CFE_OP_MOVLW     8'h0E
`define CFE_OP_MOVLB     12'h010
`define CFE_OP_MOVWF     7'h37
`define CFE_OP_MOVF      6'h14
`define CFE_OP_ADDWF     6'h09
`define CFE_OP_TBLRD     16'h0008

`endif

/* File: src/cfe_dmem_addr.v */
// Purpose: forms the 12-bit data address of one access
// Assumes: combinational, same clock domain as the caller
// Notes:   full addresses bypass both bank_select and the fast window
`timescale 1ns/1ps
`include "cfe_map.vh"

module cfe_dmem_addr (
  // instruction fields
  input  wire                    access_bank,
  input  wire [7:0]              offset,
  input  wire                    full_en,
  input  wire [`CFE_DA_W-1:0]    full_addr,
  // banking state
  input  wire [`CFE_BANK_W-1:0]  bank_select,
  // result
  output reg  [`CFE_DA_W-1:0]    addr
);

  always @* begin
    if (full_en) begin
      addr = full_addr;
    end else if (!access_bank) begin
      // low part of window is bank 0, high part is the top bank
      if (offset < `CFE_ACC_SPLIT) begin
        addr = {`CFE_ACC_LO_BANK, offset}; // RULE16 RULE18
      end else begin
        addr = {`CFE_ACC_HI_BANK, offset}; // RULE18
      end
    end else begin
      addr = {bank_select, offset}; // RULE19 RULE13
    end
  end

endmodule

/* File: src/cfe_pipe.v */
// Purpose: quadrature sequencer and two-stage fetch/execute pipeline
// Assumes: program and data memories answer on clk, one cycle after a strobe
// Notes:   small core opcode subset; stack and peripheral SFRs live outside
`timescale 1ns/1ps
`include "cfe_map.vh"

// How it works
// RULE1 - clock divided by four into phases
// RULE2 - pc steps in phase_one, fetch latched phase_four
// RULE3 - latched word presented phase_one, executed after
// RULE4 - operand read phase_two, result write phase_four
// RULE5 - fetch overlaps execute, one per cycle
// RULE6 - pc change flushes fetched word, two cycles
// RULE7 - byte addressed program memory, even word start
// RULE8 - pc steps by two, bit zero zero
// RULE9 - absolute target loads pc bits 20:1
// RULE10 - branch offset counts single words
// RULE11 - second word tagged 1111, twelve literal bits
// RULE12 - lone tagged word executes as nop
// RULE13 - twelve bit data address, sixteen banks
// RULE14 - all banks implemented
// RULE15 - unimplemented location reads zero
// RULE16 - fast window reachable without bank_select
// RULE17 - table read fetches one byte into latch
// RULE18 - window low to bank 0, high to bank 15
// RULE19 - bank_select gives upper four address bits
// RULE20 - reset empties pipeline, first cycle fetches only
module cfe_pipe (
  // clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // quadrature phases
  output wire                    phase_one,
  output wire                    phase_two,
  output wire                    phase_three,
  output wire                    phase_four,
  // program memory
  output reg  [`CFE_PC_W-1:0]    pmem_addr,
  output reg                     pmem_rd,
  input  wire [`CFE_WORD_W-1:0]  pmem_rd_data,
  // table read port
  input  wire [`CFE_PC_W-1:0]    table_pointer,
  output reg  [`CFE_PC_W-1:0]    tbl_addr,
  output reg                     tbl_rd,
  input  wire [7:0]              tbl_rd_byte,
  output reg  [7:0]              table_latch,
  // data memory
  output reg  [`CFE_DA_W-1:0]    dmem_addr,
  output reg                     dmem_rd,
  input  wire [7:0]              dmem_rd_data,
  input  wire                    dmem_impl,
  output reg                     dmem_wr,
  output reg  [7:0]              dmem_wr_data,
  // stack and pointer side effects
  output reg                     call_push,
  output reg  [`CFE_PC_W-1:0]    call_ret_addr,
  output reg                     ptr_load,
  output reg  [1:0]              ptr_sel,
  output reg  [`CFE_DA_W-1:0]    ptr_value,
  // visible core state
  output reg  [`CFE_PC_W-1:0]    pc,
  output reg  [`CFE_WORD_W-1:0]  instruction_latch,
  output reg                     exec_valid,
  output reg  [7:0]              wreg,
  output reg  [`CFE_BANK_W-1:0]  bank_select
);

  // pending second-word kinds, one-hot; zero means none
  localparam [3:0] PEND_NONE  = 4'h0;
  // jumps and calls act in their leader's cycle, reading the tail off the
  // fetch bus, so they never leave a pending kind behind
  localparam [3:0] PEND_REGISTER_TO_REGISTER_MOVE = 4'h4;
  localparam [3:0] PEND_LFSR  = 4'h8;

  reg  [3:0]              phase;
  reg  [`CFE_PC_W-1:0]    fetch_addr;
  reg  [`CFE_PC_W-1:0]    exec_addr;
  reg  [`CFE_WORD_W-1:0]  fetch_word;
  reg                     fetch_valid;
  reg  [3:0]              pend;
  reg  [11:0]             pend_lo;
  reg  [7:0]              operand;

  // decode of the word in execution
  reg                     d_read;
  reg                     d_write;
  reg                     d_full;
  reg  [`CFE_DA_W-1:0]    d_full_addr;
  reg                     d_to_w;
  reg                     d_add;
  reg                     d_movwf;
  reg                     d_register_to_register_move_w;
  reg                     d_redirect;
  reg  [`CFE_PC_W-1:0]    d_target;
  reg  [3:0]              next_pend;
  reg                     d_call;
  reg                     d_lfsr;
  reg                     d_movlw;
  reg                     d_movlb;
  reg                     d_tblrd;

  wire [15:0]             il = instruction_latch;
  wire [`CFE_DA_W-1:0]    eff_addr;
  wire [`CFE_PC_W-1:0]    bra_off;
  wire [`CFE_PC_W-1:0]    fall_thru;
  wire [7:0]              rd_byte;

  assign phase_one   = phase[0];
  assign phase_two   = phase[1];
  assign phase_three = phase[2];
  assign phase_four  = phase[3];

  // signed word count doubled into a byte offset
  assign bra_off   = {{9{il[10]}}, il[10:0], 1'b0}; // RULE10
  assign fall_thru = exec_addr + `CFE_PC_STEP;
  // absent locations answer as zero whatever the bus carries
  assign rd_byte   = dmem_impl ? dmem_rd_data : 8'h00; // RULE15 RULE14

  cfe_dmem_addr u_addr (
    .access_bank (il[8]),
    .offset      (il[7:0]),
    .full_en     (d_full),
    .full_addr   (d_full_addr),
    .bank_select (bank_select),
    .addr        (eff_addr)
  );

  // phase ring: a rotating one-hot, so phases never overlap
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= `CFE_PH_ONE;
    end else begin
      case (phase)
        `CFE_PH_ONE:   phase <= `CFE_PH_TWO;   // RULE1
        `CFE_PH_TWO:   phase <= `CFE_PH_THREE; // RULE1
        `CFE_PH_THREE: phase <= `CFE_PH_FOUR;  // RULE1
        `CFE_PH_FOUR:  phase <= `CFE_PH_ONE;   // RULE1
        default:       phase <= `CFE_PH_ONE;
      endcase
    end
  end

  // decode; only meaningful while exec_valid
  always @* begin
    d_read      = 1'b0;
    d_write     = 1'b0;
    d_full      = 1'b0;
    d_full_addr = {`CFE_DA_W{1'b0}};
    d_to_w      = 1'b0;
    d_add       = 1'b0;
    d_movwf     = 1'b0;
    d_register_to_register_move_w   = 1'b0;
    d_redirect  = 1'b0;
    d_target    = fall_thru;
    next_pend   = PEND_NONE;
    d_call      = 1'b0;
    d_lfsr      = 1'b0;
    d_movlw     = 1'b0;
    d_movlb     = 1'b0;
    d_tblrd     = 1'b0;
    if (exec_valid) begin
      if (pend != PEND_NONE && il[15:12] == `CFE_TAIL_TAG) begin
        // tail word consumed as literal data of its leader
        case (pend)
          PEND_REGISTER_TO_REGISTER_MOVE: begin
            d_write     = 1'b1; // RULE11
            d_full      = 1'b1;
            d_full_addr = il[11:0];
            d_register_to_register_move_w   = 1'b1;
          end
          PEND_LFSR: begin
            d_lfsr = 1'b1; // RULE11
          end
          default: begin
            d_lfsr = 1'b0;
          end
        endcase
      end else if (il[15:12] == `CFE_TAIL_TAG) begin
        // reached without its leader (skipped into): nothing happens
        d_lfsr = 1'b0; // RULE12
      end else if (il[15:8] == `CFE_OP_GOTO) begin
        // the tail stands on the fetch bus in phase_four; jumping now and
        // dropping the tail keeps a jump to two instruction cycles
        d_redirect = 1'b1; // RULE6 RULE11
        d_target   = {pmem_rd_data[11:0], il[7:0], 1'b0}; // RULE9
      end else if (il[15:9] == `CFE_OP_CALL) begin
        // same timing as a jump, plus the push
        d_redirect = 1'b1; // RULE6 RULE11
        d_call     = 1'b1;
        d_target   = {pmem_rd_data[11:0], il[7:0], 1'b0}; // RULE9
      end else if (il[15:8] == `CFE_OP_LFSR && il[7:6] == 2'b00) begin
        next_pend = PEND_LFSR;
      end else if (il[15:12] == `CFE_OP_REGISTER_TO_REGISTER_MOVE) begin
        next_pend   = PEND_REGISTER_TO_REGISTER_MOVE;
        d_read      = 1'b1;
        d_full      = 1'b1;
        d_full_addr = il[11:0];
      end else if (il[15:11] == `CFE_OP_BRA) begin
        d_redirect = 1'b1;
        d_target   = fall_thru + bra_off; // RULE10
      end else if (il[15:8] == `CFE_OP_MOVLW) begin
        d_movlw = 1'b1;
      end else if (il[15:4] == `CFE_OP_MOVLB) begin
        d_movlb = 1'b1;
      end else if (il[15:9] == `CFE_OP_MOVWF) begin
        d_write = 1'b1;
        d_movwf = 1'b1;
      end else if (il[15:10] == `CFE_OP_MOVF) begin
        d_read  = 1'b1;
        d_write = il[9];
        d_to_w  = !il[9];
      end else if (il[15:10] == `CFE_OP_ADDWF) begin
        d_read  = 1'b1;
        d_add   = 1'b1;
        d_write = il[9];
        d_to_w  = !il[9];
      end else if (il == `CFE_OP_TBLRD) begin
        d_tblrd = 1'b1;
      end
    end
  end

  // fetch stage and program counter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc          <= `CFE_PC_RESET;
      fetch_addr  <= `CFE_PC_RESET;
      pmem_addr   <= `CFE_PC_RESET;
      pmem_rd     <= 1'b0;
      fetch_word  <= {`CFE_WORD_W{1'b0}};
      fetch_valid <= 1'b0; // RULE20
    end else begin
      pmem_rd <= 1'b0;
      if (phase_one) begin
        fetch_addr <= pc;
        pmem_addr  <= pc; // RULE7
        pmem_rd    <= 1'b1;
        pc         <= pc + `CFE_PC_STEP; // RULE2 RULE8
      end
      if (phase_four) begin
        fetch_word <= pmem_rd_data; // RULE2
        if (d_redirect) begin
          // the word fetched alongside a flow change is thrown away
          fetch_valid <= 1'b0; // RULE6
          pc          <= d_target; // RULE6 RULE8 RULE9
        end else begin
          fetch_valid <= 1'b1; // RULE5
        end
      end
    end
  end

  // execute stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instruction_latch <= {`CFE_WORD_W{1'b0}};
      exec_valid        <= 1'b0; // RULE20
      exec_addr         <= `CFE_PC_RESET;
      pend              <= PEND_NONE;
      pend_lo           <= 12'h000;
      operand           <= 8'h00;
      wreg              <= 8'h00;
      bank_select       <= {`CFE_BANK_W{1'b0}};
      dmem_addr         <= {`CFE_DA_W{1'b0}};
      dmem_rd           <= 1'b0;
      dmem_wr           <= 1'b0;
      dmem_wr_data      <= 8'h00;
      tbl_addr          <= `CFE_PC_RESET;
      tbl_rd            <= 1'b0;
      table_latch       <= 8'h00;
      call_push         <= 1'b0;
      call_ret_addr     <= `CFE_PC_RESET;
      ptr_load          <= 1'b0;
      ptr_sel           <= 2'b00;
      ptr_value         <= {`CFE_DA_W{1'b0}};
    end else begin
      dmem_rd   <= 1'b0;
      dmem_wr   <= 1'b0;
      tbl_rd    <= 1'b0;
      call_push <= 1'b0;
      ptr_load  <= 1'b0;
      if (phase_four) begin
        // next word enters execution in the coming phase_one
        instruction_latch <= pmem_rd_data; // RULE3 RULE5
        exec_valid        <= !d_redirect; // RULE5 RULE6
        exec_addr         <= fetch_addr;
        pend              <= next_pend;
        if (next_pend != PEND_NONE) begin
          pend_lo <= il[11:0];
        end
      end
      if (phase_one) begin
        // operand strobe stands through phase_two
        dmem_addr <= eff_addr; // RULE13 RULE16 RULE19
        dmem_rd   <= d_read; // RULE4
        tbl_addr  <= table_pointer; // RULE17
        tbl_rd    <= d_tblrd; // RULE17
        if (d_movlb) begin
          bank_select <= il[3:0];
        end
      end
      if (phase_three) begin
        // memory answers during phase_three; write strobe stands in phase_four
        if (d_read) begin
          operand <= rd_byte; // RULE4 RULE15
        end
        if (d_tblrd) begin
          table_latch <= tbl_rd_byte; // RULE17
        end
        dmem_addr <= eff_addr;
        dmem_wr   <= d_write; // RULE4
        if (d_movwf) begin
          dmem_wr_data <= wreg;
        end else if (d_register_to_register_move_w) begin
          dmem_wr_data <= operand;
        end else if (d_add) begin
          dmem_wr_data <= rd_byte + wreg;
        end else begin
          dmem_wr_data <= rd_byte;
        end
      end
      if (phase_four) begin
        if (d_to_w) begin
          wreg <= d_add ? operand + wreg : operand; // RULE4
        end
        if (d_movlw) begin
          wreg <= il[7:0];
        end
        if (d_call) begin
          call_push     <= 1'b1;
          // return lands past the dropped tail word
          call_ret_addr <= fall_thru + `CFE_PC_STEP;
        end
        if (d_lfsr) begin
          ptr_load  <= 1'b1;
          ptr_sel   <= pend_lo[5:4];
          ptr_value <= {pend_lo[3:0], il[7:0]}; // RULE11
        end
      end
    end
  end

endmodule

/* File: tb/cfe_mem_model.sv */
// Purpose: program and data memory partner of the pipeline
// Assumes: answers on clk; slow holds fetch data back to phase_four
// Notes:   unfetched or unready lines show inverted data, not the last word
`timescale 1ns/1ps
module cfe_mem_model #(parameter [11:0] HOLE = 12'hF60) (
  // clock and pacing
  input  wire        clk,
  input  wire        slow,
  // program side
  input  wire [20:0] pmem_addr,
  input  wire        pmem_rd,
  output wire [15:0] pmem_rd_data,
  input  wire [20:0] tbl_addr,
  input  wire        tbl_rd,
  output reg  [7:0]  tbl_rd_byte,
  // data side
  input  wire [11:0] dmem_addr,
  input  wire        dmem_rd,
  output reg  [7:0]  dmem_rd_data,
  output reg         dmem_impl,
  input  wire        dmem_wr,
  input  wire [7:0]  dmem_wr_data
);
  reg [15:0] pm [0:63];
  reg [7:0]  dm [0:4095];
  reg [15:0] w;
  reg        wait_one;
  reg [1:0]  age;
  // word stands in phase_four (and phase_three when prompt), inverted otherwise
  assign pmem_rd_data = (wait_one || age > 2'h1) ? ~w : w;
  always @(posedge clk) begin
    if (pmem_rd) begin
      w <= pm[pmem_addr[6:1]];
      wait_one <= slow;
      age <= 2'h0;
    end else begin
      wait_one <= 1'b0;
      if (age != 2'h3) age <= age + 2'h1;
    end
    // odd table address gives the high byte of the word
    tbl_rd_byte <= tbl_rd ? (tbl_addr[0] ? pm[tbl_addr[6:1]][15:8]
                                         : pm[tbl_addr[6:1]][7:0]) : ~tbl_rd_byte;
    // a hole returns junk so the core must force zero itself
    dmem_impl <= dmem_addr != HOLE;
    dmem_rd_data <= (dmem_rd && dmem_addr != HOLE) ? dm[dmem_addr] : 8'hA5;
    if (dmem_wr && dmem_addr != HOLE)
      dm[dmem_addr] <= dmem_wr_data;
  end
endmodule

/* File: tb/cfe_pipe_checker.sv */
// Purpose: timing checks on the pipeline ports
// Assumes: one clock domain, nrst async active low
// Notes:   goto flush check keys on the opcode in the latch
`timescale 1ns/1ps
`include "cfe_map.vh"
module cfe_pipe_checker (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // observed ports
  input wire        phase_one,
  input wire        phase_two,
  input wire        phase_three,
  input wire        phase_four,
  input wire [20:0] pmem_addr,
  input wire        pmem_rd,
  input wire        dmem_rd,
  input wire        dmem_wr,
  input wire        tbl_rd,
  input wire [20:0] tbl_addr,
  input wire [20:0] table_pointer,
  input wire        call_push,
  input wire        ptr_load,
  input wire [20:0] pc,
  input wire [15:0] instruction_latch,
  input wire        exec_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  reg first;
  always @(posedge clk or negedge nrst)
    if (!nrst) first <= 1'b1;
    else if (phase_four) first <= 1'b0;
  a_phase_onehot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
    else $error("phases not one-hot");
  a_phase_order: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
    else $error("phase order broken");
  a_fetch_strobe: assert property (pmem_rd == phase_two)
    else $error("fetch strobe off phase");
  a_pc_advance: assert property (phase_two |-> pmem_addr == $past(pc) && pc == pmem_addr + 21'h000002)
    else $error("pc step wrong");
  a_word_align: assert property (!pc[0] && !pmem_addr[0])
    else $error("odd program address");
  a_latch_phase: assert property ($changed(instruction_latch) |-> phase_one)
    else $error("latch changed off phase_one");
  a_data_phases: assert property ((dmem_rd |-> phase_two) and (dmem_wr |-> phase_four))
    else $error("data access off phase");
  a_reset_empty: assert property (first |-> !exec_valid && !dmem_wr)
    else $error("stale execute after reset");
  a_goto_flush: assert property (phase_one && exec_valid && instruction_latch[15:8] == `CFE_OP_GOTO
    |-> ##4 !exec_valid)
    else $error("jump did not flush");
  a_one_per_cycle: assert property (phase_one && exec_valid && instruction_latch[15:9] == `CFE_OP_MOVWF
    |-> ##4 exec_valid)
    else $error("bubble after plain op");
  a_side_pulses: assert property ((call_push || ptr_load) |-> phase_one)
    else $error("side pulse off phase");
  a_table_read: assert property (tbl_rd |-> phase_two && tbl_addr == $past(table_pointer))
    else $error("table read wrong");
  c_call: cover property (call_push);
  c_ptr: cover property (ptr_load);
  c_tbl: cover property (tbl_rd);
endmodule
bind cfe_pipe cfe_pipe_checker chk (.clk, .nrst, .phase_one, .phase_two, .phase_three,
  .phase_four, .pmem_addr, .pmem_rd, .dmem_rd, .dmem_wr, .tbl_rd, .tbl_addr, .table_pointer,
  .call_push, .ptr_load, .pc, .instruction_latch, .exec_valid);

/* File: tb/cfe_pipe_test.sv */
// Purpose: runs a small program through the pipeline, prompt and slow memory
// Assumes: partner model holds program and data memory
// Notes:   expected writes and side pulses are queued and matched in order
`timescale 1ns/1ps
module cfe_pipe_test;
  reg         clk, nrst, slow;
  reg  [20:0] table_pointer;
  wire        phase_one, phase_two, phase_three, phase_four, pmem_rd, tbl_rd, dmem_rd;
  wire        dmem_impl, dmem_wr, call_push, ptr_load, exec_valid;
  wire [20:0] pmem_addr, tbl_addr, call_ret_addr, pc;
  wire [15:0] pmem_rd_data, instruction_latch;
  wire [11:0] dmem_addr, ptr_value;
  wire [7:0]  tbl_rd_byte, table_latch, dmem_rd_data, dmem_wr_data, wreg;
  wire [1:0]  ptr_sel;
  wire [3:0]  bank_select;
  reg  [15:0] prog [0:31];
  reg  [31:0] exp [$];
  reg  [31:0] rnd;
  reg  [7:0]  tb_byte;
  integer     errors, comparisons, run, n;
  cfe_pipe dut (.clk, .nrst, .phase_one, .phase_two, .phase_three, .phase_four, .pmem_addr,
    .pmem_rd, .pmem_rd_data, .table_pointer, .tbl_addr, .tbl_rd, .tbl_rd_byte, .table_latch,
    .dmem_addr, .dmem_rd, .dmem_rd_data, .dmem_impl, .dmem_wr, .dmem_wr_data, .call_push,
    .call_ret_addr, .ptr_load, .ptr_sel, .ptr_value, .pc, .instruction_latch, .exec_valid,
    .wreg, .bank_select);
  cfe_mem_model mem (.clk, .slow, .pmem_addr, .pmem_rd, .pmem_rd_data, .tbl_addr, .tbl_rd,
    .tbl_rd_byte, .dmem_addr, .dmem_rd, .dmem_rd_data, .dmem_impl, .dmem_wr, .dmem_wr_data);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (exp.size() == 0 || exp[0] !== got) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp.size() ? exp[0] : 32'h0);
      end
      if (exp.size()) void'(exp.pop_front());
    end
  endtask
  task check(input [31:0] got, input [31:0] want);
    begin
      comparisons = comparisons + 1;
      if (got !== want) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge clk) if (nrst) begin
    if (dmem_wr) cmp({4'h1, 8'h00, dmem_addr, dmem_wr_data});
    if (ptr_load) cmp({4'h2, 14'h0000, ptr_sel, ptr_value});
    if (call_push) cmp({4'h3, 7'h00, call_ret_addr});
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    table_pointer = 21'h000000;
    rnd = 32'hEF431003;
    errors = 0;
    comparisons = 0;
    for (n = 0; n < 32; n = n + 1) prog[n] = 16'h0000;
    // plain ops, banked and window writes, hole read, register_to_register_move, lfsr, call, goto
    {prog[0], prog[1], prog[2], prog[3], prog[4], prog[5], prog[6], prog[7]} =
      {16'h0E55, 16'h6E20, 16'h0103, 16'h6F40, 16'h5060, 16'h6E21, 16'hC020, 16'hF456};
    {prog[8], prog[9], prog[10], prog[11], prog[12], prog[13], prog[14], prog[15]} =
      {16'hEE11, 16'hF023, 16'hEC0E, 16'hF000, 16'h6E2F, 16'h0EAA, 16'h0008, 16'hEF12};
    {prog[16], prog[17], prog[18], prog[19], prog[20], prog[21]} =
      {16'hF000, 16'h0E11, 16'hF123, 16'h2420, 16'h6E22, 16'hD7FF};
    for (n = 0; n < 32; n = n + 1) mem.pm[n] = prog[n];
    for (run = 0; run < 2; run = run + 1) begin
      @(posedge clk);
      nrst <= 1'b0;
      slow <= run[0];
      rnd = lfsr(rnd);
      table_pointer <= {15'h0000, rnd[5:0]};
      repeat (10) @(posedge clk);
      exp = '{32'h10002055, 32'h10034055, 32'h10002100, 32'h10045655,
              32'h20001123, 32'h30000018, 32'h10002255};
      nrst <= 1'b1;
      n = 0;
      while (exp.size() != 0 && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      if (exp.size() != 0) begin
        errors = errors + 1;
        wrap_up;
      end
      for (n = 0; n < 32; n = n + 1) begin
        @(posedge clk);
        if (phase_two && pmem_addr > 21'h00002C) check({11'h0, pmem_addr}, 32'h2C);
      end
      tb_byte = table_pointer[0] ? prog[table_pointer[5:1]][15:8]
                                 : prog[table_pointer[5:1]][7:0];
      check({24'h0, table_latch}, {24'h0, tb_byte});
      check({24'h0, wreg}, 32'h55);
      check({28'h0, bank_select}, 32'h3);
      $display("run %0d finished", run);
    end
    wrap_up;
  end
endmodule
